// File: rtl/mfrsd_cfg.svh
// Offsets, window sizes and type codes for the register space decode
`ifndef MFRSD_CFG_SVH
`define MFRSD_CFG_SVH
`define MFRSD_CFG_SPACE_BITS   8
`define MFRSD_SOCK_WIN_BITS    12
`define MFRSD_SOCK16_OFF       12'h800
`define MFRSD_LINK_WIN_BITS    11
`define MFRSD_MEDIA_WIN_BITS   8
`define MFRSD_LEGACY_INDEX     32'h0000_03E0
`define MFRSD_LEGACY_DATA      32'h0000_03E2
`define MFRSD_PHY_CTRL_OFF     12'h0EC
`define MFRSD_SOCK_EVT_OFF     12'h000
`define MFRSD_TYPE0_CODE       2'h0
`define MFRSD_TYPE1_CODE       2'h1
`define MFRSD_CB_IDSEL_BIT     16
`define MFRSD_NUM_FUNC         3'h5
`endif

// File: rtl/mfrsd_pkg.sv
// Types shared by the register space decode
`default_nettype none
package mfrsd_pkg;
    typedef enum logic [1:0] {
        MFRSD_KIND_CFG,
        MFRSD_KIND_MEM,
        MFRSD_KIND_IO
    } mfrsd_kind_t;
    typedef enum logic [3:0] {
        MFRSD_RG_NONE,
        MFRSD_RG_CFG,
        MFRSD_RG_SOCK32,
        MFRSD_RG_SOCK16,
        MFRSD_RG_LINK,
        MFRSD_RG_MEDIA0,
        MFRSD_RG_MEDIA1,
        MFRSD_RG_MEDIA2,
        MFRSD_RG_CBCFG
    } mfrsd_region_t;
endpackage : mfrsd_pkg
`default_nettype wire

// File: rtl/mfrsd_decode.sv
// Address space decode for a multi-function bridge device
`include "mfrsd_cfg.svh"
`default_nettype none
module mfrsd_decode (
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    input  wire logic                 req_valid,
    input  wire mfrsd_pkg::mfrsd_kind_t req_kind,
    input  wire logic                 req_write,
    input  wire logic [31:0]          req_addr,
    input  wire logic [7:0]           req_wdata,
    input  wire logic                 mem_space_en,
    input  wire logic                 io_space_en,
    input  wire logic                 legacy_mode_en,
    input  wire logic [7:0]           secondary_bus,
    input  wire logic [31:0]          sock_base,
    input  wire logic                 sock_base_en,
    input  wire logic [31:0]          link_base,
    input  wire logic                 link_base_en,
    input  wire logic [31:0]          media0_base,
    input  wire logic                 media0_base_en,
    input  wire logic [31:0]          media1_base,
    input  wire logic                 media1_base_en,
    input  wire logic [31:0]          media2_base,
    input  wire logic                 media2_base_en,
    input  wire logic                 sock_chg_pin,
    input  wire logic                 sock_wake_pin,
    input  wire logic                 card_present_pin,
    output logic                      dec_hit,
    output mfrsd_pkg::mfrsd_region_t  dec_region,
    output logic [11:0]               dec_offset,
    output logic [2:0]                dec_func,
    output logic                      phy_ctrl_hit,
    output logic                      cb_cfg_valid,
    output logic [31:0]               cb_cfg_addr,
    output logic [2:0]                sock_status
);
    // Window hit: address and base agree above the window size
    function automatic logic in_win(input logic [31:0] a,
                                    input logic [31:0] b,
                                    input int unsigned sh);
        in_win = ((a ^ b) >> sh) == 32'h0;
    endfunction : in_win

    logic        mem_req, io_req, cfg0_req, cfg1_req;
    logic        sock_hit, link_hit, m0_hit, m1_hit, m2_hit;
    logic        leg_idx_hit, leg_dat_hit;
    logic [7:0]  leg_index_reg;
    mfrsd_pkg::mfrsd_region_t region_next;
    logic [11:0] offset_next;

    assign mem_req  = req_valid && req_kind == mfrsd_pkg::MFRSD_KIND_MEM
                      && mem_space_en;
    assign io_req   = req_valid && req_kind == mfrsd_pkg::MFRSD_KIND_IO
                      && io_space_en;
    assign cfg0_req = req_valid && req_kind == mfrsd_pkg::MFRSD_KIND_CFG
                      && req_addr[1:0] == `MFRSD_TYPE0_CODE
                      && req_addr[10:8] < `MFRSD_NUM_FUNC;
    // Only device 0 exists behind the card bus
    assign cfg1_req = req_valid && req_kind == mfrsd_pkg::MFRSD_KIND_CFG
                      && req_addr[1:0] == `MFRSD_TYPE1_CODE
                      && req_addr[23:16] == secondary_bus
                      && req_addr[15:11] == 5'h00;

    assign sock_hit = mem_req && sock_base_en
        && in_win(req_addr, sock_base, `MFRSD_SOCK_WIN_BITS);
    assign link_hit = mem_req && link_base_en
        && in_win(req_addr, link_base, `MFRSD_LINK_WIN_BITS);
    assign m0_hit = mem_req && media0_base_en
        && in_win(req_addr, media0_base, `MFRSD_MEDIA_WIN_BITS);
    assign m1_hit = mem_req && media1_base_en
        && in_win(req_addr, media1_base, `MFRSD_MEDIA_WIN_BITS);
    assign m2_hit = mem_req && media2_base_en
        && in_win(req_addr, media2_base, `MFRSD_MEDIA_WIN_BITS);
    assign leg_idx_hit = io_req && legacy_mode_en
        && req_addr == `MFRSD_LEGACY_INDEX;
    assign leg_dat_hit = io_req && legacy_mode_en
        && req_addr == `MFRSD_LEGACY_DATA;

    // Overlapping windows resolve in this fixed order
    always_comb begin
        region_next = mfrsd_pkg::MFRSD_RG_NONE;
        offset_next = 12'h000;
        if (cfg0_req) begin
            region_next = mfrsd_pkg::MFRSD_RG_CFG;
            offset_next = {4'h0, req_addr[7:2], 2'h0};
        end else if (cfg1_req) begin
            region_next = mfrsd_pkg::MFRSD_RG_CBCFG;
            offset_next = {4'h0, req_addr[7:2], 2'h0};
        end else if (sock_hit) begin
            offset_next = req_addr[11:0];
            if (req_addr[11]) begin
                region_next = mfrsd_pkg::MFRSD_RG_SOCK16;
            end else begin
                region_next = mfrsd_pkg::MFRSD_RG_SOCK32;
            end
        end else if (link_hit) begin
            region_next = mfrsd_pkg::MFRSD_RG_LINK;
            offset_next = {1'b0, req_addr[10:0]};
        end else if (m0_hit) begin
            region_next = mfrsd_pkg::MFRSD_RG_MEDIA0;
            offset_next = {4'h0, req_addr[7:0]};
        end else if (m1_hit) begin
            region_next = mfrsd_pkg::MFRSD_RG_MEDIA1;
            offset_next = {4'h0, req_addr[7:0]};
        end else if (m2_hit) begin
            region_next = mfrsd_pkg::MFRSD_RG_MEDIA2;
            offset_next = {4'h0, req_addr[7:0]};
        end else if (leg_dat_hit) begin
            region_next = mfrsd_pkg::MFRSD_RG_SOCK16;
            offset_next = `MFRSD_SOCK16_OFF | {4'h0, leg_index_reg};
        end
    end

    // Index port write steers later data port accesses
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            leg_index_reg <= 8'h00;
        end else if (leg_idx_hit && req_write) begin
            leg_index_reg <= req_wdata;
        end
    end

    // Index port is claimed but needs no routing downstream
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dec_hit    <= 1'b0;
            dec_region <= mfrsd_pkg::MFRSD_RG_NONE;
            dec_offset <= 12'h000;
            dec_func   <= 3'h0;
        end else begin
            dec_hit    <= region_next != mfrsd_pkg::MFRSD_RG_NONE
                          || leg_idx_hit;
            dec_region <= region_next;
            dec_offset <= offset_next;
            dec_func   <= req_addr[10:8];
        end
    end

    // PHY has no window of its own, only the control word in the link block
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phy_ctrl_hit <= 1'b0;
        end else begin
            phy_ctrl_hit <= region_next == mfrsd_pkg::MFRSD_RG_LINK
                && offset_next == `MFRSD_PHY_CTRL_OFF;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cb_cfg_valid <= 1'b0;
            cb_cfg_addr  <= 32'h0000_0000;
        end else begin
            cb_cfg_valid <= cfg1_req;
            cb_cfg_addr  <= (32'h1 << `MFRSD_CB_IDSEL_BIT)
                | {21'h0, req_addr[10:2], `MFRSD_TYPE0_CODE};
        end
    end

    // Socket event capture; pins are asynchronous
    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;
    logic [1:0] pin_prev_reg;
    logic       chg_reg, wake_reg;
    logic       evt_clear, chg_rise, wake_rise;
    assign evt_clear = sock_hit && req_write && !req_addr[11]
                       && req_addr[11:0] == `MFRSD_SOCK_EVT_OFF;
    assign chg_rise  = pin_s2_reg[0] && !pin_prev_reg[0];
    assign wake_rise = pin_s2_reg[1] && !pin_prev_reg[1];
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_s1_reg   <= 3'h0;
            pin_s2_reg   <= 3'h0;
            pin_prev_reg <= 2'h0;
        end else begin
            pin_s1_reg   <= {card_present_pin, sock_wake_pin, sock_chg_pin};
            pin_s2_reg   <= pin_s1_reg;
            pin_prev_reg <= pin_s2_reg[1:0];
        end
    end
    // A new event in the clearing cycle stays set
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            chg_reg  <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            chg_reg  <= chg_rise || (chg_reg && !evt_clear);
            wake_reg <= wake_rise || (wake_reg && !evt_clear);
        end
    end

    assign sock_status = {pin_s2_reg[2], wake_reg, chg_reg};

    sequence s_type1_req;
        req_valid && req_kind == mfrsd_pkg::MFRSD_KIND_CFG
        && req_addr[1:0] == 2'h1 && req_addr[23:16] == secondary_bus
        && req_addr[15:11] == 5'h00;
    endsequence
    sequence s_type0_out;
        cb_cfg_valid && cb_cfg_addr[1:0] == 2'h0 && cb_cfg_addr[16]
        && dec_region == mfrsd_pkg::MFRSD_RG_CBCFG;
    endsequence
    sequence s_index_write;
        leg_idx_hit && req_write;
    endsequence

    property p_cfg_own;
        @(posedge mclk) disable iff (sys_rst)
        cfg0_req |=> dec_hit && dec_region == mfrsd_pkg::MFRSD_RG_CFG
                     && dec_offset[11:8] == 4'h0;
    endproperty
    a_cfg_own: assert property (p_cfg_own)
        else $error("own config access not decoded");
    property p_type1;
        @(posedge mclk) disable iff (sys_rst)
        s_type1_req |=> s_type0_out;
    endproperty
    a_type1: assert property (p_type1)
        else $error("type 1 access not forwarded as type 0");
    property p_sock32;
        @(posedge mclk) disable iff (sys_rst)
        sock_hit && !req_addr[11] && !cfg0_req && !cfg1_req
        |=> dec_region == mfrsd_pkg::MFRSD_RG_SOCK32
            && dec_offset < 12'h800;
    endproperty
    a_sock32: assert property (p_sock32)
        else $error("lower socket half misdecoded");
    property p_sock16;
        @(posedge mclk) disable iff (sys_rst)
        sock_hit && req_addr[11] && !cfg0_req && !cfg1_req
        |=> dec_region == mfrsd_pkg::MFRSD_RG_SOCK16
            && dec_offset >= 12'h800;
    endproperty
    a_sock16: assert property (p_sock16)
        else $error("upper socket half misdecoded");
    // Index byte is taken two cycles before the offset shows
    property p_legacy;
        @(posedge mclk) disable iff (sys_rst)
        s_index_write ##1 (leg_dat_hit && !leg_idx_hit)
        |=> dec_region == mfrsd_pkg::MFRSD_RG_SOCK16
            && dec_offset == {4'h8, $past(req_wdata, 2)};
    endproperty
    a_legacy: assert property (p_legacy)
        else $error("legacy data port did not follow index");
    property p_link;
        @(posedge mclk) disable iff (sys_rst)
        link_hit && !sock_hit && !cfg0_req && !cfg1_req
        |=> dec_region == mfrsd_pkg::MFRSD_RG_LINK
            && dec_offset[11] == 1'b0;
    endproperty
    a_link: assert property (p_link)
        else $error("link window misdecoded");
    property p_phy;
        @(posedge mclk) disable iff (sys_rst)
        phy_ctrl_hit |-> dec_region == mfrsd_pkg::MFRSD_RG_LINK
                         && dec_offset == 12'h0EC;
    endproperty
    a_phy: assert property (p_phy)
        else $error("PHY control flagged outside link block");
    property p_miss;
        @(posedge mclk) disable iff (sys_rst)
        req_valid && req_kind == mfrsd_pkg::MFRSD_KIND_MEM && !mem_space_en
        |=> !dec_hit;
    endproperty
    a_miss: assert property (p_miss)
        else $error("access claimed with memory space disabled");
    property p_event;
        @(posedge mclk) disable iff (sys_rst)
        $rose(pin_s2_reg[0]) |=> sock_status[0];
    endproperty
    a_event: assert property (p_event)
        else $error("status change event lost");
    property p_media;
        @(posedge mclk) disable iff (sys_rst)
        m0_hit && !sock_hit && !link_hit && !cfg0_req && !cfg1_req
        |=> dec_region == mfrsd_pkg::MFRSD_RG_MEDIA0
            && dec_offset[11:8] == 4'h0;
    endproperty
    a_media: assert property (p_media)
        else $error("first media window misdecoded");
endmodule : mfrsd_decode
`default_nettype wire

// File: test/mfrsd_host.sv
// Host model that drives one decode request per call
`default_nettype none
module mfrsd_host (
    output var logic                   req_valid,
    output var mfrsd_pkg::mfrsd_kind_t req_kind,
    output var logic                   req_write,
    output var logic [31:0]            req_addr,
    output var logic [7:0]             req_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        req_addr = 32'h0000_0000;
        req_wdata = 8'h00;
        idle();
    end
    // Called just after a falling edge, so the request settles early
    task automatic send(input mfrsd_pkg::mfrsd_kind_t k, input logic w,
                        input logic [31:0] a, input logic [7:0] d);
        req_valid = 1'b1;
        req_kind = k;
        req_write = w;
        req_addr = a;
        req_wdata = d;
    endtask : send
    // Released address and data lines flip so a stale value is never mistaken for a request
    task automatic idle();
        req_valid = 1'b0;
        req_kind = mfrsd_pkg::MFRSD_KIND_IO;
        req_write = 1'b0;
        req_addr = ~req_addr;
        req_wdata = ~req_wdata;
    endtask : idle
endmodule : mfrsd_host
`default_nettype wire

// File: test/mfrsd_decode_bench.sv
// Self-checking bench for the register space decode
`default_nettype none
module mfrsd_decode_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000;
    logic mclk, sys_rst, req_valid, req_write, dec_hit, phy_ctrl_hit;
    logic mem_space_en, io_space_en, legacy_mode_en, sock_base_en;
    logic link_base_en, cb_cfg_valid, e_hit, e_phy, e_cbv, chk_off;
    logic [2:0]  pins, me, dec_func, sock_status, e_fn;
    logic [7:0]  req_wdata, secondary_bus, idx;
    logic [11:0] dec_offset, e_off;
    logic [3:0]  e_rg;
    logic [31:0] req_addr, sock_base, link_base, cb_cfg_addr, e_cba, off;
    logic [31:0] mb [3];
    mfrsd_pkg::mfrsd_kind_t   req_kind;
    mfrsd_pkg::mfrsd_region_t dec_region;
    int fail_count, num_checks, cycles;

    mfrsd_host i_mfrsd_host (.req_valid(req_valid), .req_kind(req_kind),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata));
    mfrsd_decode i_mfrsd_decode (.mclk(mclk), .sys_rst(sys_rst),
        .req_valid(req_valid), .req_kind(req_kind), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata),
        .mem_space_en(mem_space_en), .io_space_en(io_space_en),
        .legacy_mode_en(legacy_mode_en), .secondary_bus(secondary_bus),
        .sock_base(sock_base), .sock_base_en(sock_base_en),
        .link_base(link_base), .link_base_en(link_base_en),
        .media0_base(mb[0]), .media0_base_en(me[0]),
        .media1_base(mb[1]), .media1_base_en(me[1]),
        .media2_base(mb[2]), .media2_base_en(me[2]),
        .sock_chg_pin(pins[0]), .sock_wake_pin(pins[1]),
        .card_present_pin(pins[2]), .dec_hit(dec_hit),
        .dec_region(dec_region), .dec_offset(dec_offset),
        .dec_func(dec_func), .phy_ctrl_hit(phy_ctrl_hit),
        .cb_cfg_valid(cb_cfg_valid), .cb_cfg_addr(cb_cfg_addr),
        .sock_status(sock_status));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Reference decode; the bench keeps its own copy of the legacy index
    task automatic predict(input mfrsd_pkg::mfrsd_kind_t k, input logic w,
                           input logic [31:0] a, input logic [7:0] d);
        {e_hit, e_phy, e_cbv} = 3'h0;
        e_rg = mfrsd_pkg::MFRSD_RG_NONE;
        e_off = a[11:0];
        e_fn = a[10:8];
        e_cba = {15'h0, 1'b1, 5'h0, a[10:8], a[7:2], 2'h0};
        if (k == mfrsd_pkg::MFRSD_KIND_CFG) begin
            e_off = {4'h0, a[7:2], 2'h0};
            if (a[1:0] == 2'h0 && a[10:8] < 3'h5) begin
                e_hit = 1'b1;
                e_rg = mfrsd_pkg::MFRSD_RG_CFG;
            end else if (a[1:0] == 2'h1 && a[23:16] == secondary_bus
                         && a[15:11] == 5'h00) begin
                {e_hit, e_cbv} = 2'h3;
                e_rg = mfrsd_pkg::MFRSD_RG_CBCFG;
            end
        end else if (k == mfrsd_pkg::MFRSD_KIND_MEM && mem_space_en) begin
            if (sock_base_en && a[31:12] == sock_base[31:12]) begin
                e_hit = 1'b1;
                e_rg = a[11] ? mfrsd_pkg::MFRSD_RG_SOCK16
                             : mfrsd_pkg::MFRSD_RG_SOCK32;
            end else if (link_base_en && a[31:11] == link_base[31:11]) begin
                e_hit = 1'b1;
                e_rg = mfrsd_pkg::MFRSD_RG_LINK;
                e_off = {1'b0, a[10:0]};
                e_phy = (a[10:0] == 11'h0EC);
            end
            for (int i = 0; i < 3; i++) begin
                if (!e_hit && me[i] && a[31:8] == mb[i][31:8]) begin
                    e_hit = 1'b1;
                    e_rg = 4'(mfrsd_pkg::MFRSD_RG_MEDIA0) + 4'(i);
                    e_off = {4'h0, a[7:0]};
                end
            end
        end else if (k == mfrsd_pkg::MFRSD_KIND_IO && io_space_en
                     && legacy_mode_en) begin
            // Index port is claimed on reads too; only writes load it
            if (a == 32'h0000_03E0) begin
                e_hit = 1'b1;
                if (w) begin
                    idx = d;
                end
            end else if (a == 32'h0000_03E2) begin
                e_hit = 1'b1;
                e_rg = mfrsd_pkg::MFRSD_RG_SOCK16;
                e_off = {4'h8, idx};
            end
        end
        chk_off = e_hit && e_rg != 4'h0;
    endtask : predict

    task automatic req(input mfrsd_pkg::mfrsd_kind_t k, input logic w,
                       input logic [31:0] a, input logic [7:0] d);
        predict(k, w, a, d);
        i_mfrsd_host.send(k, w, a, d);
        @(negedge mclk);
        check(dec_hit, e_hit);
        check(dec_region, e_rg);
        check(phy_ctrl_hit, e_phy);
        check(cb_cfg_valid, e_cbv);
        if (e_cbv) check(cb_cfg_addr, e_cba);
        if (chk_off) check(dec_offset, e_off);
        if (e_hit && k == mfrsd_pkg::MFRSD_KIND_CFG) begin
            check(dec_func, e_fn);
        end
    endtask : req

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    initial begin
        {sys_rst, mem_space_en, io_space_en, legacy_mode_en} = 4'h F;
        {sock_base_en, link_base_en, me, pins} = 8'hF8;
        {fail_count, num_checks, cycles, idx} = '0;
        secondary_bus = 8'h05;
        sock_base = 32'h8000_0000;
        link_base = 32'h8000_1000;
        mb = '{32'h8000_2000, 32'h8000_2100, 32'h8000_2200};
        void'($urandom(32'h04fd));
        repeat (8) @(negedge mclk);
        check(dec_hit, 1'b0);
        sys_rst = 1'b0;
        for (int b = 0; b < 3; b++) begin
            pins[b] = 1'b1;
            @(negedge mclk);
            check(sock_status[b], 1'b0);
            repeat (3) @(negedge mclk);
            check(sock_status[b], 1'b1);
            pins[b] = 1'b0;
            repeat (4) @(negedge mclk);
            check(sock_status[b], b < 2);
        end
        req(mfrsd_pkg::MFRSD_KIND_MEM, 1'b1, sock_base | 32'h4, 8'h00);
        repeat (3) @(negedge mclk);
        check(sock_status, 3'h3);
        req(mfrsd_pkg::MFRSD_KIND_MEM, 1'b1, sock_base, 8'h00);
        repeat (3) @(negedge mclk);
        check(sock_status, 3'h0);
        // Back-to-back requests with random enables exercise refusals too
        for (int n = 0; n < 600; n++) begin
            off = $urandom;
            {mem_space_en, io_space_en, legacy_mode_en} =
                off[31:29] != 3'h0 ? 3'h7 : 3'($urandom);
            {sock_base_en, link_base_en, me} =
                off[28:26] != 3'h0 ? 5'h1F : 5'($urandom);
            case ($urandom % 7)
                0: req(mfrsd_pkg::MFRSD_KIND_MEM, 1'b0,
                       sock_base | off[11:0], 8'h00);
                1: req(mfrsd_pkg::MFRSD_KIND_MEM, 1'b0,
                       link_base | (off[25] ? 32'h0EC : off[10:0]), 8'h00);
                2: req(mfrsd_pkg::MFRSD_KIND_MEM, 1'b0,
                       mb[off[9:8] % 3] | off[7:0], 8'h00);
                3: req(mfrsd_pkg::MFRSD_KIND_CFG, 1'b0,
                       {21'h0, off[10:2], 2'h0}, 8'h00);
                4: req(mfrsd_pkg::MFRSD_KIND_CFG, 1'b0, {8'h00,
                       off[24] ? secondary_bus : off[23:16],
                       off[13] ? 5'h00 : off[15:11], 3'(off[10:8] % 5),
                       off[7:2], 2'h1}, 8'h00);
                5: begin
                    // A read of the index port must leave the index alone
                    req(mfrsd_pkg::MFRSD_KIND_IO, off[8], 32'h0000_03E0,
                        off[7:0]);
                    req(mfrsd_pkg::MFRSD_KIND_IO, 1'b0, 32'h0000_03E2, 8'h00);
                end
                default: req(off[0] ? mfrsd_pkg::MFRSD_KIND_IO
                                    : mfrsd_pkg::MFRSD_KIND_MEM,
                             1'b0, 32'h4001_0000 | off[15:0], 8'h00);
            endcase
        end
        i_mfrsd_host.idle();
        @(negedge mclk);
        test_done();
    end
endmodule : mfrsd_decode_bench
`default_nettype wire
